// [core/pic_op_pkg.sv]
// Constants shared by the cascaded interrupt controller pair
package pic_op_pkg;

	// ----------------------------------------------------------------
	// I/O port addresses (low address byte)
	// ----------------------------------------------------------------
	localparam logic [7:0] PRI_CMD_ADDR = 8'h20;
	localparam logic [7:0] PRI_DATA_ADDR = 8'h21;
	localparam logic [7:0] SEC_CMD_ADDR = 8'ha0;
	localparam logic [7:0] SEC_DATA_ADDR = 8'ha1;

	// ----------------------------------------------------------------
	// Command word field positions
	// ----------------------------------------------------------------
	localparam int INIT_SEL_BIT = 4;
	localparam int WORD_SEL_BIT = 3;
	localparam int CMD_HI_BIT = 7;
	localparam int CMD_LO_BIT = 5;
	localparam int LVL_HI_BIT = 2;
	localparam int SMM_BIT = 6;
	localparam int SPECIAL_MASKING_ENABLE_BIT = 5;
	localparam int POLL_BIT = 2;
	localparam int RSEL_EN_BIT = 1;
	localparam int RSEL_BIT = 0;
	localparam int POLL_VALID_BIT = 7;

	// ----------------------------------------------------------------
	// Priority command codes
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_AUTOMATIC_END_OF_INTERRUPT_ROT_CLR = 3'h0;
	localparam logic [2:0] CMD_NS_EOI = 3'h1;
	localparam logic [2:0] CMD_NOP = 3'h2;
	localparam logic [2:0] CMD_SP_EOI = 3'h3;
	localparam logic [2:0] CMD_AUTOMATIC_END_OF_INTERRUPT_ROT_SET = 3'h4;
	localparam logic [2:0] CMD_ROT_NS_EOI = 3'h5;
	localparam logic [2:0] CMD_SET_PRI = 3'h6;
	localparam logic [2:0] CMD_ROT_SP_EOI = 3'h7;

	// ----------------------------------------------------------------
	// Reset values and fixed wiring
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] REG_CLEAR = 8'h00;
	localparam logic [2:0] LOW_PRI_RESET = 3'h7;
	localparam logic [2:0] CASCADE_CH = 3'h2;
	localparam int PRI = 0;
	localparam int SEC = 1;

endpackage

// [core/pic_request_sync.sv]
// Request pin synchroniser and rising edge detector
`timescale 1ns/1ps
module pic_request_sync
	import pic_op_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Request pins and detected edges
	input wire logic [15:0] req_i,
	output logic [15:0] rise_o
);

	typedef struct packed {
		logic [15:0] meta;
		logic [15:0] sync;
		logic [15:0] prev;
	} sync_t;

	sync_t st;
	sync_t next_st;

	always_comb begin
		next_st = st;
		next_st.meta = req_i;
		next_st.sync = st.meta;
		next_st.prev = st.sync;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Edge seen on second and third stage only, never on the first
	assign rise_o = st.sync & ~st.prev;

	a_rise_single: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rise_o != 16'h0000) |=> ((rise_o & $past(rise_o)) == 16'h0000))
		else $error("request edge lasted more than one cycle");

endmodule

// [core/pic_operational_control.sv]
// Operational control of a cascaded primary/secondary interrupt controller pair
`timescale 1ns/1ps

// Function
// - Mask bit one stops that channel's requests from setting its request bit.
// - Mask bit zero lets that channel's requests be accepted again.
// - Masking primary input two blocks every secondary controller request.
// - Command port write with bits four and three zero is a priority command.
// - Codes 001 nonspecific END_OF_INTERRUPT_COMMAND, 011 specific END_OF_INTERRUPT_COMMAND, 010 no operation.
// - 101 rotate on nonspecific END_OF_INTERRUPT_COMMAND, 111 rotate on specific, 110 set priority.
// - 100 enables rotation in automatic END_OF_INTERRUPT_COMMAND mode, 000 disables it.
// - With level select set, low three bits pick the channel acted on.
// - After reset or init: fully nested, nonspecific END_OF_INTERRUPT_COMMAND, no rotation.
// - Command port write with bits four and three 01 is mask/poll/select word.
// - Enable and mode set enter special mask, enable alone returns to normal.
// - Poll bit makes next read an acknowledge returning the top level code.
// - Select bit one set: bit zero picks request or in-service for reads.
// - Chosen status register persists over reads, request register after init.
// - Data port read returns the mask register directly, unless a poll is armed.
// - Masking a high input leaves lower inputs' acceptance untouched.
module pic_operational_control
	import pic_op_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_B_I,
	// Host I/O cycle, one-cycle strobes
	input wire logic [7:0] IO_ADDR_I,
	input wire logic IO_WR_I,
	input wire logic IO_RD_I,
	input wire logic [7:0] IO_WDATA_I,
	output logic [7:0] IO_RDATA_O,
	// Interrupt request pins, channels 15..0
	input wire logic [15:0] IRQ_I,
	// Processor interrupt and acknowledge
	input wire logic AUTO_EOI_I,
	input wire logic INTA_I,
	output logic INTR_O,
	output logic ACK_VALID_O,
	output logic [3:0] ACK_LEVEL_O
);

	typedef struct packed {
		logic [1:0][7:0] request_latch_register;
		logic [1:0][7:0] in_service_register;
		logic [1:0][7:0] channel_mask_register;
		logic [1:0][2:0] low_pri;
		logic [1:0] ris;
		logic [1:0] special_masking_bit;
		logic [1:0] rot_automatic_end_of_interrupt;
		logic [1:0] poll;
		logic intr;
		logic [7:0] rdata;
		logic ack_valid;
		logic [3:0] ack_level;
	} ctl_t;

	ctl_t st;
	ctl_t next_st;
	logic [15:0] rise;
	logic [1:0][3:0] req_res;
	logic [1:0][3:0] isr_res;
	logic [1:0] pend;
	logic wr_hit, rd_hit, acc_ctl, acc_odd;
	logic [2:0] dec;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Rank 0 is the highest priority: the level just above the lowest
	function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
		rank = 3'(lvl - low - 3'h1);
	endfunction

	// Returns {found, level} of the highest priority set bit
	function automatic logic [3:0] resolve(input logic [7:0] vec, input logic [2:0] low);
		logic [2:0] idx;
		resolve = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			idx = 3'(low + 3'(i) + 3'h1);
			if (vec[idx]) begin
				resolve = {1'b1, idx};
			end
		end
	endfunction

	function automatic logic [2:0] decode(input logic [7:0] addr);
		decode = 3'h0;
		case (addr)
			PRI_CMD_ADDR: decode = 3'h4;
			PRI_DATA_ADDR: decode = 3'h5;
			SEC_CMD_ADDR: decode = 3'h6;
			SEC_DATA_ADDR: decode = 3'h7;
			default: decode = 3'h0;
		endcase
	endfunction

	pic_request_sync u_sync (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.req_i(IRQ_I),
		.rise_o(rise)
	);

	// A function result cannot be part-selected, so it is held in a net first
	assign dec = decode(IO_ADDR_I);
	assign acc_ctl = dec[1];
	assign acc_odd = dec[0];
	assign wr_hit = IO_WR_I && dec[2];
	assign rd_hit = IO_RD_I && dec[2];

	// ----------------------------------------------------------------
	// Priority resolution
	// ----------------------------------------------------------------
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			// mask gates only its own channel
			req_res[c] = resolve(st.request_latch_register[c] & ~st.channel_mask_register[c], st.low_pri[c]);
			isr_res[c] = resolve(st.in_service_register[c], st.low_pri[c]);
			// Special mask lets any unmasked level through regardless of nesting
			pend[c] = req_res[c][3] && (st.special_masking_bit[c] || !isr_res[c][3] ||
				(rank(req_res[c][2:0], st.low_pri[c]) < rank(isr_res[c][2:0], st.low_pri[c])));
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0] ack;
		logic [2:0] lvl;
		logic [2:0] cmd;
		ack = 2'b00;
		lvl = IO_WDATA_I[LVL_HI_BIT:0];
		cmd = IO_WDATA_I[CMD_HI_BIT:CMD_LO_BIT];
		next_st = st;
		next_st.ack_valid = 1'b0;

		if (wr_hit && acc_odd) begin
			// mask written as a whole byte
			next_st.channel_mask_register[acc_ctl] = IO_WDATA_I;
		end else if (wr_hit && IO_WDATA_I[INIT_SEL_BIT]) begin
			// first init word restores operating defaults
			next_st.channel_mask_register[acc_ctl] = MASK_RESET;
			next_st.in_service_register[acc_ctl] = REG_CLEAR;
			next_st.low_pri[acc_ctl] = LOW_PRI_RESET;
			next_st.ris[acc_ctl] = 1'b0;
			next_st.special_masking_bit[acc_ctl] = 1'b0;
			next_st.rot_automatic_end_of_interrupt[acc_ctl] = 1'b0;
			next_st.poll[acc_ctl] = 1'b0;
		end else if (wr_hit && !IO_WDATA_I[WORD_SEL_BIT]) begin
			case (cmd)
				// nonspecific END_OF_INTERRUPT_COMMAND clears top in-service level
				CMD_NS_EOI: begin
					if (isr_res[acc_ctl][3]) begin
						next_st.in_service_register[acc_ctl][isr_res[acc_ctl][2:0]] = 1'b0;
					end
				end
				// rotate so the served level becomes lowest
				CMD_ROT_NS_EOI: begin
					if (isr_res[acc_ctl][3]) begin
						next_st.in_service_register[acc_ctl][isr_res[acc_ctl][2:0]] = 1'b0;
						next_st.low_pri[acc_ctl] = isr_res[acc_ctl][2:0];
					end
				end
				CMD_SP_EOI: begin
					next_st.in_service_register[acc_ctl][lvl] = 1'b0;
				end
				CMD_ROT_SP_EOI: begin
					next_st.in_service_register[acc_ctl][lvl] = 1'b0;
					next_st.low_pri[acc_ctl] = lvl;
				end
				CMD_SET_PRI: begin
					next_st.low_pri[acc_ctl] = lvl;
				end
				CMD_AUTOMATIC_END_OF_INTERRUPT_ROT_SET: begin
					next_st.rot_automatic_end_of_interrupt[acc_ctl] = 1'b1;
				end
				CMD_AUTOMATIC_END_OF_INTERRUPT_ROT_CLR: begin
					next_st.rot_automatic_end_of_interrupt[acc_ctl] = 1'b0;
				end
				default: begin
					next_st.rot_automatic_end_of_interrupt[acc_ctl] = st.rot_automatic_end_of_interrupt[acc_ctl];
				end
			endcase
		end else if (wr_hit) begin
			// mask mode, poll and read select word
			// mode bit only counts when enable is set
			if (IO_WDATA_I[SPECIAL_MASKING_ENABLE_BIT]) begin
				next_st.special_masking_bit[acc_ctl] = IO_WDATA_I[SMM_BIT];
			end
			// arm poll for the next read
			next_st.poll[acc_ctl] = IO_WDATA_I[POLL_BIT];
			if (IO_WDATA_I[RSEL_EN_BIT]) begin
				next_st.ris[acc_ctl] = IO_WDATA_I[RSEL_BIT];
			end
		end

		if (rd_hit) begin
			if (st.poll[acc_ctl]) begin
				next_st.poll[acc_ctl] = 1'b0;
				next_st.rdata = {pend[acc_ctl], 4'h0, req_res[acc_ctl][2:0]};
				ack[acc_ctl] = pend[acc_ctl];
			end else if (acc_odd) begin
				next_st.rdata = st.channel_mask_register[acc_ctl];
			end else begin
				next_st.rdata = st.ris[acc_ctl] ? st.in_service_register[acc_ctl] : st.request_latch_register[acc_ctl];
			end
		end

		if (INTA_I && pend[PRI]) begin
			ack[PRI] = 1'b1;
			ack[SEC] = ack[SEC] || (req_res[PRI][2:0] == CASCADE_CH && pend[SEC]);
			next_st.ack_valid = 1'b1;
			next_st.ack_level = (req_res[PRI][2:0] == CASCADE_CH && pend[SEC]) ?
				{1'b1, req_res[SEC][2:0]} : {1'b0, req_res[PRI][2:0]};
		end

		for (int c = 0; c < 2; c++) begin
			if (ack[c]) begin
				next_st.request_latch_register[c][req_res[c][2:0]] = 1'b0;
				if (!AUTO_EOI_I) begin
					next_st.in_service_register[c][req_res[c][2:0]] = 1'b1;
				end else if (st.rot_automatic_end_of_interrupt[c]) begin
					next_st.low_pri[c] = req_res[c][2:0];
				end
			end
		end

		// new edges latch only into unmasked channels, after any clear
		next_st.request_latch_register[SEC] = next_st.request_latch_register[SEC] | (rise[15:8] & ~next_st.channel_mask_register[SEC]);
		next_st.request_latch_register[PRI] = next_st.request_latch_register[PRI] | (rise[7:0] & ~next_st.channel_mask_register[PRI]);
		// cascade input follows the secondary and obeys primary mask two
		next_st.request_latch_register[PRI][CASCADE_CH] = pend[SEC] && !next_st.channel_mask_register[PRI][CASCADE_CH];
		next_st.intr = pend[PRI];
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			// nested mode, no rotation, request register selected
			st <= '0;
			st.low_pri <= {LOW_PRI_RESET, LOW_PRI_RESET};
			st.channel_mask_register <= {MASK_RESET, MASK_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign IO_RDATA_O = st.rdata;
	assign INTR_O = st.intr;
	assign ACK_VALID_O = st.ack_valid;
	assign ACK_LEVEL_O = st.ack_level;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	a_mask_write_byte: assert property (
		(wr_hit && acc_odd) |=> st.channel_mask_register[$past(acc_ctl)] == $past(IO_WDATA_I))
		else $error("mask byte not stored");
	a_mask_blocks_set: assert property (
		!IO_WR_I |=> ((st.request_latch_register[SEC] & ~$past(st.request_latch_register[SEC]) & $past(st.channel_mask_register[SEC])) == 8'h00))
		else $error("masked channel set its request bit");
	a_cascade_masked: assert property (
		st.channel_mask_register[PRI][CASCADE_CH] |-> !st.request_latch_register[PRI][CASCADE_CH])
		else $error("cascade request passed a set mask");
	a_eoi_clears_one: assert property (
		(wr_hit && !acc_odd && !acc_ctl && IO_WDATA_I[7:3] == {CMD_NS_EOI, 2'b00}
		&& st.in_service_register[PRI] != 8'h00 && !INTA_I && !rd_hit)
		|=> $countones(st.in_service_register[PRI]) == $countones($past(st.in_service_register[PRI])) - 1)
		else $error("nonspecific END_OF_INTERRUPT_COMMAND did not clear one level");
	a_set_priority: assert property (
		(wr_hit && !acc_odd && acc_ctl && IO_WDATA_I[7:3] == {CMD_SET_PRI, 2'b00} && !rd_hit
		&& !INTA_I) |=> st.low_pri[SEC] == $past(IO_WDATA_I[2:0]))
		else $error("set priority not applied");
	a_automatic_end_of_interrupt_rotate: assert property (
		(wr_hit && !acc_odd && IO_WDATA_I[7:3] == {CMD_AUTOMATIC_END_OF_INTERRUPT_ROT_SET, 2'b00})
		|=> st.rot_automatic_end_of_interrupt[$past(acc_ctl)])
		else $error("automatic END_OF_INTERRUPT_COMMAND rotation not enabled");
	a_init_defaults: assert property (
		(wr_hit && !acc_odd && IO_WDATA_I[INIT_SEL_BIT]) |=> st.low_pri[$past(acc_ctl)]
		== LOW_PRI_RESET && !st.ris[$past(acc_ctl)] && !st.special_masking_bit[$past(acc_ctl)])
		else $error("init did not restore defaults");
	a_special_mask: assert property (
		(wr_hit && !acc_odd && IO_WDATA_I[7:3] == 5'h01) |=> $stable(st.special_masking_bit))
		else $error("mode bit acted without enable");
	a_poll_answer: assert property (
		(rd_hit && st.poll[acc_ctl]) |=> IO_RDATA_O[POLL_VALID_BIT] == $past(pend[acc_ctl])
		&& !st.poll[$past(acc_ctl)])
		else $error("poll read answer wrong");
	a_status_select: assert property (
		(rd_hit && !acc_odd && !st.poll[acc_ctl]) |=> IO_RDATA_O ==
		($past(st.ris[acc_ctl]) ? $past(st.in_service_register[acc_ctl]) : $past(st.request_latch_register[acc_ctl])))
		else $error("status read returned wrong register");
	a_select_kept: assert property (
		!wr_hit |=> $stable(st.ris))
		else $error("read selection changed without a write");
	a_mask_read: assert property (
		(rd_hit && acc_odd && !st.poll[acc_ctl]) |=> IO_RDATA_O == $past(st.channel_mask_register[acc_ctl]))
		else $error("mask read wrong");
	a_read_holds: assert property (
		!rd_hit |=> $stable(IO_RDATA_O))
		else $error("read data changed without a read");

	c_cascade_ack: cover property (INTA_I && pend[PRI] && pend[SEC]
		&& req_res[PRI][2:0] == CASCADE_CH);
	c_poll_read: cover property (rd_hit && st.poll[acc_ctl] && pend[acc_ctl]);
	c_rotate_eoi: cover property (wr_hit && !acc_odd && IO_WDATA_I[7:5] == CMD_ROT_NS_EOI
		&& st.in_service_register[acc_ctl] != 8'h00);
	c_special_mask: cover property (st.special_masking_bit[PRI] && INTA_I && pend[PRI] && st.in_service_register[PRI] != 8'h00);

endmodule

// [verif/pic_host_model.sv]
// Host processor model that answers the interrupt output with acknowledge pulses
`timescale 1ns/1ps
module pic_host_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Interrupt handshake
	input wire logic intr_i,
	input wire logic ack_en_i,
	input wire logic [1:0] ack_dly_i,
	output logic inta_o
);
	logic [1:0] wait_cnt;
	logic [1:0] gap;

	// ----------------------------------------------------------------
	// Acknowledge generation
	// ----------------------------------------------------------------
	// The output lags by a cycle, so after each pulse the model waits
	// before it trusts the interrupt level again.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			inta_o <= 1'b0;
			wait_cnt <= 2'h0;
			gap <= 2'h0;
		end else begin
			inta_o <= 1'b0;
			if (gap != 2'h0) begin
				gap <= gap - 2'h1;
			end else if (ack_en_i && intr_i && !inta_o) begin
				if (wait_cnt == ack_dly_i) begin
					inta_o <= 1'b1;
					wait_cnt <= 2'h0;
					gap <= 2'h3;
				end else begin
					wait_cnt <= wait_cnt + 2'h1;
				end
			end else begin
				wait_cnt <= 2'h0;
			end
		end
	end
endmodule

// [verif/tb_pic_operational_control.sv]
// Self-checking testbench for the interrupt controller operational control
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_pic_operational_control;
	import pic_op_pkg::*;
	logic clk, rst_b, io_wr, io_rd, auto_eoi, inta, ack_en, got;
	logic [7:0] io_addr, io_wdata, m, r, pend, rv;
	logic [15:0] irq;
	logic [1:0] ack_dly;
	logic [2:0] low, lvl;
	wire logic [7:0] rdata;
	wire logic intr, ack_valid;
	wire logic [3:0] ack_level;
	int error_cnt = 0;
	int check_count = 0;
	int n;

	pic_operational_control u_pic_operational_control (.CLK_I(clk), .RST_B_I(rst_b),
		.IO_ADDR_I(io_addr), .IO_WR_I(io_wr), .IO_RD_I(io_rd), .IO_WDATA_I(io_wdata),
		.IO_RDATA_O(rdata), .IRQ_I(irq), .AUTO_EOI_I(auto_eoi), .INTA_I(inta),
		.INTR_O(intr), .ACK_VALID_O(ack_valid), .ACK_LEVEL_O(ack_level));
	pic_host_model u_pic_host_model (.clk_i(clk), .rst_b_i(rst_b), .intr_i(intr),
		.ack_en_i(ack_en), .ack_dly_i(ack_dly), .inta_o(inta));

	// ----------------------------------------------------------------
	// Clock, verdict and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize;
		if (error_cnt == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		summarize;
	end

	// ----------------------------------------------------------------
	// Bus tasks and expectations
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask

	task automatic chkrd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		#1 rv = rdata;
		`CHK(rv, exp)
	endtask

	// Bounded wait for one acknowledge answer from the design
	task automatic wait_ack;
		got = 1'b0;
		for (int k = 0; k < 40 && !got; k++) begin
			@(posedge clk);
			#1 got = (ack_valid === 1'b1);
		end
		`CHK(got, 1'b1)
	endtask

	// Next level served after the lowest-priority one, ring order
	function automatic logic [2:0] win(input logic [7:0] v, input logic [2:0] lo);
		logic [2:0] idx;
		logic [2:0] res;
		logic hit;
		res = 3'h0;
		hit = 1'b0;
		idx = lo;
		for (int i = 0; i < 8; i++) begin
			idx = idx + 3'h1;
			if (v[idx] && !hit) begin
				res = idx;
				hit = 1'b1;
			end
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		io_addr = 8'h00;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		irq = 16'h0000;
		auto_eoi = 1'b0;
		ack_en = 1'b0;
		ack_dly = 2'h0;
		rst_b = 1'b0;
		void'($urandom(49670));
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		chkrd(PRI_DATA_ADDR, MASK_RESET);
		chkrd(PRI_CMD_ADDR, REG_CLEAR);
		// Channel two stays clear so the cascade input does not mix in
		m = 8'($urandom()) & 8'hfb;
		r = (8'($urandom()) & 8'hfb) | 8'h01;
		wr(PRI_DATA_ADDR, m);
		chkrd(PRI_DATA_ADDR, m);
		@(posedge clk) irq <= {8'h00, r};
		repeat (6) @(posedge clk);
		chkrd(PRI_CMD_ADDR, r & ~m);
		@(posedge clk) irq <= 16'h0000;
		wr(PRI_DATA_ADDR, MASK_RESET);
		@(posedge clk) irq <= {8'h00, r};
		repeat (6) @(posedge clk);
		chkrd(PRI_CMD_ADDR, r);
		chkrd(PRI_CMD_ADDR, r);
		wr(PRI_CMD_ADDR, 8'h0b);
		chkrd(PRI_CMD_ADDR, REG_CLEAR);
		lvl = win(r, LOW_PRI_RESET);
		wr(PRI_CMD_ADDR, 8'h0c);
		chkrd(PRI_CMD_ADDR, {1'b1, 4'h0, lvl});
		chkrd(PRI_CMD_ADDR, 8'h01 << lvl);
		wr(PRI_CMD_ADDR, 8'h0a);
		chkrd(PRI_CMD_ADDR, r & ~(8'h01 << lvl));
		wr(PRI_CMD_ADDR, 8'h0b);
		wr(PRI_CMD_ADDR, {CMD_NOP, 5'h00});
		chkrd(PRI_CMD_ADDR, 8'h01 << lvl);
		wr(PRI_CMD_ADDR, {CMD_NS_EOI, 5'h00});
		chkrd(PRI_CMD_ADDR, REG_CLEAR);
		pend = r & ~(8'h01 << lvl);
		low = 3'($urandom());
		wr(PRI_CMD_ADDR, {CMD_SET_PRI, 2'b00, low});
		for (n = 0; pend != 8'h00; n++) begin
			lvl = win(pend, low);
			wr(PRI_CMD_ADDR, 8'h0c);
			chkrd(PRI_CMD_ADDR, {1'b1, 4'h0, lvl});
			chkrd(PRI_CMD_ADDR, 8'h01 << lvl);
			case (n % 3)
				0: wr(PRI_CMD_ADDR, {CMD_SP_EOI, 2'b00, lvl});
				1: begin
					wr(PRI_CMD_ADDR, {CMD_ROT_SP_EOI, 2'b00, lvl});
					low = lvl;
				end
				default: begin
					wr(PRI_CMD_ADDR, {CMD_ROT_NS_EOI, 5'h00});
					low = lvl;
				end
			endcase
			chkrd(PRI_CMD_ADDR, REG_CLEAR);
			pend[lvl] = 1'b0;
		end
		// Secondary request behind a masked cascade input
		wr(PRI_DATA_ADDR, 8'h04);
		@(posedge clk) irq <= 16'h0200;
		ack_dly <= 2'($urandom());
		repeat (8) @(posedge clk);
		#1 `CHK(intr, 1'b0)
		@(posedge clk) ack_en <= 1'b1;
		wr(PRI_DATA_ADDR, MASK_RESET);
		wait_ack();
		`CHK(ack_level, 4'h9)
		// Automatic END_OF_INTERRUPT_COMMAND with rotation: served level becomes lowest
		wr(PRI_CMD_ADDR, {CMD_NS_EOI, 5'h00});
		wr(PRI_CMD_ADDR, {CMD_SET_PRI, 2'b00, 3'h1});
		wr(PRI_CMD_ADDR, {CMD_AUTOMATIC_END_OF_INTERRUPT_ROT_SET, 5'h00});
		@(posedge clk) begin
			auto_eoi <= 1'b1;
			irq <= 16'h0001;
		end
		wait_ack();
		`CHK(ack_level, 4'h0)
		@(posedge clk) irq <= 16'h0000;
		repeat (4) @(posedge clk);
		@(posedge clk) irq <= 16'h0003;
		wait_ack();
		`CHK(ack_level, 4'h1)
		chkrd(PRI_CMD_ADDR, REG_CLEAR);
		@(posedge clk) begin
			auto_eoi <= 1'b0;
			irq <= 16'h0000;
		end
		repeat (8) @(posedge clk);
		wr(PRI_DATA_ADDR, m);
		chkrd(PRI_DATA_ADDR, m);
		chkrd(8'h30, m);
		wr(PRI_CMD_ADDR, 8'h11);
		chkrd(PRI_DATA_ADDR, MASK_RESET);
		summarize;
	end
endmodule
